// ==== hdl/tap_map.vh ====
// Constants for the boundary-scan test access port.
`ifndef TAP_MAP_VH
`define TAP_MAP_VH
// ----------------------------------------------------------------
// Controller states
// ----------------------------------------------------------------
`define ST_RESET      4'h0
`define ST_IDLE       4'h1
`define ST_SEL_DR     4'h2
`define ST_CAP_DR     4'h3
`define ST_SHIFT_DR   4'h4
`define ST_EXIT1_DR   4'h5
`define ST_PAUSE_DR   4'h6
`define ST_EXIT2_DR   4'h7
`define ST_UPD_DR     4'h8
`define ST_SEL_IR     4'h9
`define ST_CAP_IR     4'hA
`define ST_SHIFT_IR   4'hB
`define ST_EXIT1_IR   4'hC
`define ST_PAUSE_IR   4'hD
`define ST_EXIT2_IR   4'hE
`define ST_UPD_IR     4'hF
// ----------------------------------------------------------------
// Instructions, two-bit instruction register
// ----------------------------------------------------------------
`define IR_WIDTH      2
`define IR_EXTEST     2'h0
`define IR_SAMPLE     2'h1
`define IR_USER       2'h2
`define IR_BYPASS     2'h3
`define IR_CAPTURE    2'h1
`define IR_RESET_VAL  2'h3
// ----------------------------------------------------------------
// Register widths
// ----------------------------------------------------------------
`define BSR_WIDTH     8
`define USER_WIDTH    8
`endif

// ==== hdl/scan_cells.v ====
// Parameterised shift stage with a latched parallel output.
`timescale 1ns/100ps
module scan_cells #(
   parameter WIDTH = 8,
   parameter [WIDTH-1:0] RESET_VAL = {WIDTH{1'b0}}
) (
   input wire clk_in,               // System clock.
   input wire nrst_in,              // Asynchronous reset, active low.
   input wire tlr_in,               // Synchronous return to reset value.
   input wire capture_in,           // Parallel load of the shift stage.
   input wire shift_in,             // Shift one place toward the serial output.
   input wire update_in,            // Copy shift stage to the latch.
   input wire sin_in,               // Serial data in.
   input wire [WIDTH-1:0] pin_in,   // Parallel capture value.
   output wire sout_out,            // Serial data out.
   output reg [WIDTH-1:0] latch_out // Latched parallel output.
);
   reg [WIDTH-1:0] shift_reg;
   wire [WIDTH:0] joined;

   assign joined = {sin_in, shift_reg};
   assign sout_out = shift_reg[0];

   always @(posedge clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         shift_reg <= {WIDTH{1'b0}};
         latch_out <= RESET_VAL;
      end else begin
         if (capture_in) begin
            shift_reg <= pin_in;
         end else if (shift_in) begin
            shift_reg <= joined[WIDTH:1];
         end
         // The latch moves only on update or test logic reset, so shifting never disturbs it.
         if (tlr_in) begin
            latch_out <= RESET_VAL;
         end else if (update_in) begin
            latch_out <= shift_reg;
         end
      end
   end
endmodule

// ==== hdl/tap_controller.v ====
// Boundary-scan test access port controller with its data registers.
// Summary of operation
// - Five rising TCK with TMS high always reach the reset state.
// - Reset state holds while TMS samples high.
// - In reset the test logic is off; functional pins pass through.
// - Idle holds while TMS samples low.
// - Select-DR with TMS low starts a data register scan.
// - Select-IR with TMS low starts an instruction register scan.
// - Capture-DR loads the selected data register in parallel.
// - Shift-DR moves the selected data register one place toward TDO.
// - Pause-DR holds the data register contents.
// - Exit2-DR goes back to Shift-DR or on to Update-DR.
// - Update-DR copies the shift stage into its parallel latch.
// - Data latches change only at update or in the reset state.
// - Capture-IR loads a fixed pattern into the instruction shift stage.
// - Shift-IR moves the instruction register one place toward TDO.
// - Pause-IR holds the instruction shift stage.
// - Exit2-IR goes back to Shift-IR or on to Update-IR.
// - Update-IR makes the shifted value the current instruction.
// - Instruction register of two cells chooses test and data register.
// - Bypass and boundary-scan registers exist, plus one user register.
// - Bypass is one cell passing TDI to TDO.
// - Test reset input initialises the controller asynchronously.
// - Transitions depend only on TMS sampled at TCK rising edges.
`timescale 1ns/100ps
`include "tap_map.vh"
module tap_controller #(
   parameter BSR_WIDTH = `BSR_WIDTH,
   parameter USER_WIDTH = `USER_WIDTH
) (
   input wire clk_sys_in,                    // System clock, 100 MHz.
   input wire nrst_in,                       // Asynchronous reset, active low.
   input wire ce_in,                         // Clock enable, freezes all state when low.
   input wire tck_in,                        // Test clock pin.
   input wire tms_in,                        // Test mode select pin.
   input wire tdi_in,                        // Test data in pin.
   input wire ntrst_in,                      // Test reset pin, active low.
   output reg tdo_out,                       // Test data out pin value.
   output reg tdo_oe_out,                    // Test data out enable, high while driving.
   input wire [BSR_WIDTH-1:0] core_pins_in,  // Functional values heading for the pins.
   input wire [BSR_WIDTH-1:0] pads_in,       // Values observed at the pins.
   output reg [BSR_WIDTH-1:0] pads_out,      // Values driven onto the pins.
   input wire [USER_WIDTH-1:0] user_obs_in,  // Status captured by the user register.
   output reg [USER_WIDTH-1:0] user_ctl_out, // Latched user register output.
   output reg [3:0] tap_state_out,           // Current controller state.
   output reg [`IR_WIDTH-1:0] instr_out      // Current instruction.
);
   // -------------------------------------------------------------
   // Pin synchronisers
   // -------------------------------------------------------------
   reg [1:0] tck_sync_reg;
   reg [1:0] tms_sync_reg;
   reg [1:0] tdi_sync_reg;
   reg [1:0] trst_sync_reg;
   reg tck_prev_reg;
   wire tck_rise;
   wire tck_fall;
   wire trst_active;

   // The test reset is asynchronous at the state register; the synchronised
   // copy only keeps it asserted cleanly for two clocks past release.
   always @(posedge clk_sys_in or negedge nrst_in) begin
      if (!nrst_in) begin
         tck_sync_reg <= 2'h0;
         tms_sync_reg <= 2'h3;
         tdi_sync_reg <= 2'h0;
         trst_sync_reg <= 2'h0;
         tck_prev_reg <= 1'b0;
      end else if (ce_in) begin
         tck_sync_reg <= {tck_sync_reg[0], tck_in};
         tms_sync_reg <= {tms_sync_reg[0], tms_in};
         tdi_sync_reg <= {tdi_sync_reg[0], tdi_in};
         trst_sync_reg <= {trst_sync_reg[0], ntrst_in};
         tck_prev_reg <= tck_sync_reg[1];
      end
   end

   // Pins are oversampled: an edge is seen three system clocks late, so each test
   // clock half period must last longer than that, which keeps the test clock
   // well below a sixth of the system clock.
   assign tck_rise = ce_in & tck_sync_reg[1] & ~tck_prev_reg;
   assign tck_fall = ce_in & ~tck_sync_reg[1] & tck_prev_reg;
   assign trst_active = ~trst_sync_reg[1];

   // -------------------------------------------------------------
   // State machine
   // -------------------------------------------------------------
   reg [3:0] state_reg;
   reg [3:0] state_next;
   wire tms;
   wire ctl_rst_n;

   assign tms = tms_sync_reg[1];
   assign ctl_rst_n = nrst_in & ntrst_in;

   always @* begin
      case (state_reg)
         `ST_RESET:    state_next = tms ? `ST_RESET : `ST_IDLE;
         `ST_IDLE:     state_next = tms ? `ST_SEL_DR : `ST_IDLE;
         `ST_SEL_DR:   state_next = tms ? `ST_SEL_IR : `ST_CAP_DR;
         `ST_CAP_DR:   state_next = tms ? `ST_EXIT1_DR : `ST_SHIFT_DR;
         `ST_SHIFT_DR: state_next = tms ? `ST_EXIT1_DR : `ST_SHIFT_DR;
         `ST_EXIT1_DR: state_next = tms ? `ST_UPD_DR : `ST_PAUSE_DR;
         `ST_PAUSE_DR: state_next = tms ? `ST_EXIT2_DR : `ST_PAUSE_DR;
         `ST_EXIT2_DR: state_next = tms ? `ST_UPD_DR : `ST_SHIFT_DR;
         `ST_UPD_DR:   state_next = tms ? `ST_SEL_DR : `ST_IDLE;
         `ST_SEL_IR:   state_next = tms ? `ST_RESET : `ST_CAP_IR;
         `ST_CAP_IR:   state_next = tms ? `ST_EXIT1_IR : `ST_SHIFT_IR;
         `ST_SHIFT_IR: state_next = tms ? `ST_EXIT1_IR : `ST_SHIFT_IR;
         `ST_EXIT1_IR: state_next = tms ? `ST_UPD_IR : `ST_PAUSE_IR;
         `ST_PAUSE_IR: state_next = tms ? `ST_EXIT2_IR : `ST_PAUSE_IR;
         `ST_EXIT2_IR: state_next = tms ? `ST_UPD_IR : `ST_SHIFT_IR;
         `ST_UPD_IR:   state_next = tms ? `ST_SEL_DR : `ST_IDLE;
         default:      state_next = `ST_RESET;
      endcase
   end

   // Every path with TMS high leads to reset within five steps.
   // The test reset clears the state at once; the synchronised copy then holds
   // reset for two more clocks, so its release never lands on a test clock edge
   // that was detected while the pin was still low.
   always @(posedge clk_sys_in or negedge ctl_rst_n) begin
      if (!ctl_rst_n) begin
         state_reg <= `ST_RESET;
      end else if (trst_active & ce_in) begin
         state_reg <= `ST_RESET;
      end else if (tck_rise) begin
         state_reg <= state_next;
      end
   end

   // -------------------------------------------------------------
   // State decodes, all but the reset decode acting on the rising test clock edge
   // -------------------------------------------------------------
   wire in_reset;
   wire cap_dr;
   wire sh_dr;
   wire upd_dr;
   wire cap_ir;
   wire sh_ir;
   wire upd_ir;

   assign in_reset = ce_in & (state_reg == `ST_RESET);
   assign cap_dr = tck_rise & (state_reg == `ST_CAP_DR);
   assign sh_dr = tck_rise & (state_reg == `ST_SHIFT_DR);
   assign upd_dr = tck_rise & (state_reg == `ST_UPD_DR);
   assign cap_ir = tck_rise & (state_reg == `ST_CAP_IR);
   assign sh_ir = tck_rise & (state_reg == `ST_SHIFT_IR);
   assign upd_ir = tck_rise & (state_reg == `ST_UPD_IR);

   // -------------------------------------------------------------
   // Instruction register
   // -------------------------------------------------------------
   wire [`IR_WIDTH-1:0] instr;
   wire ir_sout;
   reg sel_bsr;
   reg sel_user;
   reg sel_byp;
   reg drive_pads;

   scan_cells #(
      .WIDTH(`IR_WIDTH),
      .RESET_VAL(`IR_RESET_VAL)
   ) ir_cells (
      .clk_in(clk_sys_in),
      .nrst_in(ctl_rst_n),
      .tlr_in(in_reset),
      .capture_in(cap_ir),
      .shift_in(sh_ir),
      .update_in(upd_ir),
      .sin_in(tdi_sync_reg[1]),
      .pin_in(`IR_CAPTURE),
      .sout_out(ir_sout),
      .latch_out(instr)
   );

   // -------------------------------------------------------------
   // Instruction decode
   // -------------------------------------------------------------

   // The current instruction picks the data register between TDI and TDO.
   always @* begin
      sel_bsr = 1'b0;
      sel_user = 1'b0;
      sel_byp = 1'b0;
      drive_pads = 1'b0;
      case (instr)
         `IR_EXTEST: begin
            sel_bsr = 1'b1;
            drive_pads = 1'b1;
         end
         `IR_SAMPLE: begin
            sel_bsr = 1'b1;
         end
         `IR_USER: begin
            sel_user = 1'b1;
         end
         `IR_BYPASS: begin
            sel_byp = 1'b1;
         end
         default: begin
            // Unknown codes fall back to bypass so the chain length stays defined.
            sel_byp = 1'b1;
         end
      endcase
   end

   // -------------------------------------------------------------
   // Data registers
   // -------------------------------------------------------------
   wire [BSR_WIDTH-1:0] bsr_latch;
   wire [BSR_WIDTH-1:0] bsr_cap;
   wire bsr_sout;
   wire user_sout;
   wire [USER_WIDTH-1:0] user_latch;
   reg bypass_reg;

   // Input side is observed from the pads; EXTEST drives from the latch.
   assign bsr_cap = pads_in;

   scan_cells #(
      .WIDTH(BSR_WIDTH)
   ) bsr_cells (
      .clk_in(clk_sys_in),
      .nrst_in(ctl_rst_n),
      .tlr_in(in_reset),
      .capture_in(cap_dr & sel_bsr),
      .shift_in(sh_dr & sel_bsr),
      .update_in(upd_dr & sel_bsr),
      .sin_in(tdi_sync_reg[1]),
      .pin_in(bsr_cap),
      .sout_out(bsr_sout),
      .latch_out(bsr_latch)
   );

   scan_cells #(
      .WIDTH(USER_WIDTH)
   ) user_cells (
      .clk_in(clk_sys_in),
      .nrst_in(ctl_rst_n),
      .tlr_in(in_reset),
      .capture_in(cap_dr & sel_user),
      .shift_in(sh_dr & sel_user),
      .update_in(upd_dr & sel_user),
      .sin_in(tdi_sync_reg[1]),
      .pin_in(user_obs_in),
      .sout_out(user_sout),
      .latch_out(user_latch)
   );

   // Bypass captures zero as the standard prescribes for a one-cell stage.
   always @(posedge clk_sys_in or negedge ctl_rst_n) begin
      if (!ctl_rst_n) begin
         bypass_reg <= 1'b0;
      end else if (cap_dr & sel_byp) begin
         bypass_reg <= 1'b0;
      end else if (sh_dr & sel_byp) begin
         bypass_reg <= tdi_sync_reg[1];
      end
   end

   // -------------------------------------------------------------
   // Serial output and registered outputs
   // -------------------------------------------------------------
   reg dr_sout;

   always @* begin
      if (sel_bsr) begin
         dr_sout = bsr_sout;
      end else if (sel_user) begin
         dr_sout = user_sout;
      end else begin
         dr_sout = bypass_reg;
      end
   end

   reg tdo_next;
   reg tdo_oe_next;

   // A parked output reads low, so a stale bit is never mistaken for data.
   always @* begin
      tdo_oe_next = 1'b0;
      tdo_next = 1'b0;
      case (state_reg)
         `ST_SHIFT_IR: begin
            tdo_oe_next = 1'b1;
            tdo_next = ir_sout;
         end
         `ST_SHIFT_DR: begin
            tdo_oe_next = 1'b1;
            tdo_next = dr_sout;
         end
         default: begin
            tdo_oe_next = 1'b0;
            tdo_next = 1'b0;
         end
      endcase
   end

   // TDO updates on the falling edge so the host sees it stable at its rising sample.
   always @(posedge clk_sys_in or negedge ctl_rst_n) begin
      if (!ctl_rst_n) begin
         tdo_out <= 1'b0;
         tdo_oe_out <= 1'b0;
      end else if (tck_fall) begin
         tdo_oe_out <= tdo_oe_next;
         tdo_out <= tdo_next;
      end
   end

   // -------------------------------------------------------------
   // Pad and status outputs
   // -------------------------------------------------------------
   reg [BSR_WIDTH-1:0] pads_next;

   // Only EXTEST takes the pins; otherwise the core drives them.
   always @* begin
      if (drive_pads) begin
         pads_next = bsr_latch;
      end else begin
         pads_next = core_pins_in;
      end
   end

   always @(posedge clk_sys_in or negedge nrst_in) begin
      if (!nrst_in) begin
         pads_out <= {BSR_WIDTH{1'b0}};
         user_ctl_out <= {USER_WIDTH{1'b0}};
         tap_state_out <= `ST_RESET;
         instr_out <= `IR_RESET_VAL;
      end else if (ce_in) begin
         pads_out <= pads_next;
         user_ctl_out <= user_latch;
         tap_state_out <= state_reg;
         instr_out <= instr;
      end
   end
endmodule

// ==== sim/tap_checker.sv ====
// Port assertions for the test access port controller.
`timescale 1ns/100ps
`include "tap_map.vh"
module tap_checker #(
   parameter BSR_WIDTH = 8,
   parameter USER_WIDTH = 8
) (
   input wire clk_sys_in,                    // System clock.
   input wire nrst_in,                       // Asynchronous reset, active low.
   input wire tck_in,                        // Test clock pin.
   input wire tms_in,                        // Test mode select pin.
   input wire ntrst_in,                      // Test reset pin, active low.
   input wire tdo_out,                       // Test data out value.
   input wire tdo_oe_out,                    // Test data out enable.
   input wire [USER_WIDTH-1:0] user_ctl_out, // Latched user register output.
   input wire [3:0] tap_state_out,           // Current controller state.
   input wire [`IR_WIDTH-1:0] instr_out      // Current instruction.
);
   // Successor of every state for TMS low and for TMS high, four bits per state.
   localparam [63:0] NXT0 = 64'h1BDDBBA146644311;
   localparam [63:0] NXT1 = 64'h2FEFCC0287855920;
   reg [2:0] ones_reg;
   default clocking cb @(posedge clk_sys_in);
   endclocking
   default disable iff (!nrst_in);
   // Counts test clock rises with TMS high; saturates so a long run of ones stays counted.
   always @(posedge clk_sys_in or negedge nrst_in) begin
      if (!nrst_in) begin
         ones_reg <= 3'h0;
      end else if ($rose(tck_in)) begin
         ones_reg <= !tms_in ? 3'h0 : (ones_reg == 3'h7 ? 3'h7 : ones_reg + 3'h1);
      end
   end
   chk_trst_force: assert property (!ntrst_in |-> ##[0:2] tap_state_out == `ST_RESET)
      else $error("state not forced to reset by test reset");
   chk_next_state: assert property (
      $changed(tap_state_out) && ntrst_in && $past(ntrst_in) && $past(ntrst_in, 2) |->
      tap_state_out == NXT0[4*$past(tap_state_out) +: 4] || tap_state_out == NXT1[4*$past(tap_state_out) +: 4])
      else $error("illegal state transition");
   chk_five_ones: assert property (ones_reg >= 3'h5 |-> ##[0:8] tap_state_out == `ST_RESET)
      else $error("five TMS ones did not reach reset");
   chk_reset_hold: assert property (
      $rose(tck_in) && tms_in && tap_state_out == `ST_RESET |=> (tap_state_out == `ST_RESET)[*7])
      else $error("reset state left with TMS high");
   chk_idle_hold: assert property (
      $rose(tck_in) && !tms_in && ntrst_in && tap_state_out == `ST_IDLE |=> (tap_state_out == `ST_IDLE)[*7])
      else $error("idle state left with TMS low");
   chk_oe_shift: assert property (
      tdo_oe_out |-> tap_state_out inside {`ST_SHIFT_DR, `ST_EXIT1_DR, `ST_SHIFT_IR, `ST_EXIT1_IR})
      else $error("TDO driven outside a shift");
   chk_tdo_fall: assert property (ntrst_in && ($changed(tdo_out) || $changed(tdo_oe_out)) |-> !tck_in)
      else $error("TDO changed while the test clock was high");
   chk_instr_hold: assert property (
      $changed(instr_out) |-> tap_state_out inside {`ST_UPD_IR, `ST_IDLE, `ST_SEL_DR, `ST_RESET})
      else $error("instruction changed outside update");
   chk_user_hold: assert property (
      $changed(user_ctl_out) |-> tap_state_out inside {`ST_UPD_DR, `ST_IDLE, `ST_SEL_DR, `ST_RESET})
      else $error("user latch changed outside update");
endmodule
bind tap_controller tap_checker #(.BSR_WIDTH(BSR_WIDTH), .USER_WIDTH(USER_WIDTH)) chk (
   .clk_sys_in(clk_sys_in),
   .nrst_in(nrst_in),
   .tck_in(tck_in),
   .tms_in(tms_in),
   .ntrst_in(ntrst_in),
   .tdo_out(tdo_out),
   .tdo_oe_out(tdo_oe_out),
   .user_ctl_out(user_ctl_out),
   .tap_state_out(tap_state_out),
   .instr_out(instr_out)
);

// ==== sim/jtag_host.sv ====
// Behavioural test controller that drives the test access port pins.
`timescale 1ns/100ps
module jtag_host (
   input wire clk_sys_in, // Bench clock that paces the pins.
   input wire tdo_in,     // Serial data from the device.
   input wire tdo_oe_in,  // Device drive enable.
   output reg tck_out,    // Test clock, still between frames.
   output reg tms_out,    // Mode select.
   output reg tdi_out,    // Serial data to the device.
   output reg smp_out,    // Last sampled data bit.
   output reg smp_oe_out  // Drive enable seen at that sample.
);
   event got_ev;
   initial begin
      tck_out = 1'b0;
      tms_out = 1'b1;
      tdi_out = 1'b1;
      smp_out = 1'b0;
      smp_oe_out = 1'b0;
   end
   // One 160 ns test clock period; TMS and TDI move only while the clock is low.
   task step(input reg tms, input reg tdi, input reg smp);
      begin
         @(posedge clk_sys_in) #1;
         tms_out = tms;
         tdi_out = tdi;
         repeat (6) @(posedge clk_sys_in);
         #1;
         // A released line reads as the inverse, so data counts only while driven.
         smp_out = tdo_oe_in ? tdo_in : ~tdo_in;
         smp_oe_out = tdo_oe_in;
         if (smp) ->got_ev;
         @(posedge clk_sys_in) #1 tck_out = 1'b1;
         repeat (8) @(posedge clk_sys_in);
         #1 tck_out = 1'b0;
      end
   endtask
   task reset5;
      repeat (5) step(1'b1, 1'b1, 1'b0);
   endtask
endmodule

// ==== sim/tap_controller_test.sv ====
// Self-checking bench for the test access port controller.
`timescale 1ns/100ps
`include "tap_map.vh"
module tap_controller_test;
   reg clk_sys_in = 1'b0;
   reg nrst_in = 1'b0;
   reg ntrst_in = 1'b1;
   reg [7:0] core_pins_in = 8'h00;
   reg [7:0] pads_in = 8'h00;
   reg [7:0] user_obs_in = 8'h00;
   reg [7:0] d;
   reg [7:0] u;
   wire tck, tms, tdi, tdo, tdo_oe, smp, smp_oe;
   wire [7:0] pads_out;
   wire [7:0] user_ctl_out;
   wire [3:0] tap_state_out;
   wire [1:0] instr_out;
   int error_cnt = 0;
   int n_tests = 0;
   reg exp_q[$];
   always #5 clk_sys_in = ~clk_sys_in;
   tap_controller #(.BSR_WIDTH(8), .USER_WIDTH(8)) dut (
      .clk_sys_in(clk_sys_in), .nrst_in(nrst_in), .ce_in(1'b1), .tck_in(tck), .tms_in(tms), .tdi_in(tdi),
      .ntrst_in(ntrst_in), .tdo_out(tdo), .tdo_oe_out(tdo_oe), .core_pins_in(core_pins_in),
      .pads_in(pads_in), .pads_out(pads_out), .user_obs_in(user_obs_in), .user_ctl_out(user_ctl_out),
      .tap_state_out(tap_state_out), .instr_out(instr_out));
   jtag_host host (.clk_sys_in(clk_sys_in), .tdo_in(tdo), .tdo_oe_in(tdo_oe), .tck_out(tck),
      .tms_out(tms), .tdi_out(tdi), .smp_out(smp), .smp_oe_out(smp_oe));
   task results;
      begin
         $display("comparisons %0d mismatches %0d", n_tests, error_cnt);
         if (error_cnt == 0 && n_tests > 0) $display("NO MISMATCHES");
         else $display("MISMATCHES SEEN");
         $finish;
      end
   endtask
   task check_val(input string what, input reg [7:0] e, input reg [7:0] g);
      begin
         n_tests++;
         if (g !== e) begin
            error_cnt++;
            $display("unexpected %s: expected %h seen %h", what, e, g);
         end
      end
   endtask
   task check_bit(input string what, input reg e, input reg g);
      check_val(what, {7'h0, e}, {7'h0, g});
   endtask
   task st(input reg [3:0] s);
      check_val("state", {4'h0, s}, {4'h0, tap_state_out});
   endtask
   always @(host.got_ev) begin
      check_bit("tdo", exp_q.size() ? exp_q.pop_front() : 1'bx, smp);
      check_bit("tdo_oe", 1'b1, smp_oe);
   end
   // From idle through one scan and back to idle, pausing once after bit p when 0 < p < n.
   task scan(input reg ir, input reg [7:0] di, input reg [7:0] e, input int n, input int p);
      int i;
      begin
         host.step(1'b1, 1'b1, 1'b0);
         if (ir) host.step(1'b1, 1'b1, 1'b0);
         host.step(1'b0, 1'b1, 1'b0);
         host.step(1'b0, 1'b1, 1'b0);
         for (i = 0; i < n; i++) begin
            exp_q.push_back(e[i]);
            host.step(i == n - 1 || i == p - 1, di[i], 1'b1);
            if (i == p - 1 && i != n - 1) begin
               host.step(1'b0, 1'b1, 1'b0);
               host.step(1'b0, 1'b1, 1'b0);
               host.step(1'b1, 1'b1, 1'b0);
               host.step(1'b0, 1'b1, 1'b0);
            end
         end
         host.step(1'b1, 1'b1, 1'b0);
         host.step(1'b0, 1'b1, 1'b0);
      end
   endtask
   task ir_load(input reg [1:0] c);
      begin
         scan(1'b1, {6'h0, c}, {6'h0, `IR_CAPTURE}, 2, 1);
         check_val("instr", {6'h0, c}, {6'h0, instr_out});
      end
   endtask
   task to_shift;
      begin
         host.step(1'b1, 1'b1, 1'b0);
         host.step(1'b0, 1'b1, 1'b0);
         host.step(1'b0, 1'b1, 1'b0);
      end
   endtask
   initial begin
      #500000;
      error_cnt++;
      results;
   end
   initial begin
      void'($urandom(58));
      repeat (8) @(posedge clk_sys_in);
      #1 nrst_in = 1'b1;
      core_pins_in = 8'($urandom);
      repeat (4) @(posedge clk_sys_in);
      #1 check_val("instr", {6'h0, `IR_RESET_VAL}, {6'h0, instr_out});
      check_val("pads", core_pins_in, pads_out);
      host.step(1'b1, 1'b1, 1'b0);
      host.step(1'b1, 1'b1, 1'b0);
      st(`ST_RESET);
      host.step(1'b0, 1'b1, 1'b0);
      host.step(1'b0, 1'b1, 1'b0);
      st(`ST_IDLE);
      ir_load(`IR_USER);
      user_obs_in = 8'($urandom);
      u = 8'($urandom);
      scan(1'b0, u, user_obs_in, 8, 3);
      check_val("user", u, user_ctl_out);
      ir_load(`IR_BYPASS);
      d = 8'($urandom);
      scan(1'b0, d, {d[6:0], 1'b0}, 8, 0);
      check_val("user", u, user_ctl_out);
      ir_load(`IR_EXTEST);
      pads_in = 8'($urandom);
      d = 8'($urandom);
      scan(1'b0, d, pads_in, 8, 5);
      check_val("pads", d, pads_out);
      to_shift;
      host.reset5;
      st(`ST_RESET);
      check_val("pads", core_pins_in, pads_out);
      host.step(1'b0, 1'b1, 1'b0);
      ir_load(`IR_SAMPLE);
      pads_in = 8'($urandom);
      scan(1'b0, 8'($urandom), pads_in, 8, 8);
      check_val("pads", core_pins_in, pads_out);
      to_shift;
      ntrst_in = 1'b0;
      repeat (3) @(posedge clk_sys_in);
      #1 st(`ST_RESET);
      ntrst_in = 1'b1;
      check_val("pending", 8'h00, 8'(exp_q.size()));
      results;
   end
endmodule
